// ===== rtl/tws_pkg.sv
// shared constants, types and states of the two-wire slave register port
// Functional notes
// - slave only, never drives SCL or conditions
// - acknowledge only the fixed address 0110110
// - any SCL rate to 400kHz, no setting
// - SDA input on receive, open-drain low drive
// - one bit per SCL pulse, stable high
// - detect START and STOP while SCL high
// - repeated START opens a new address phase
// - idle bus watched for START and address
// - acknowledge holds SDA low through ninth pulse
// - no-acknowledge leaves SDA released through ninth
// - eight bits MSB first, then acknowledge
// - register words move low byte first
// - direction bit zero writes, one reads
// - write is address, pointer, low, high bytes
// - read needs pointer write, repeated START, read
// - device drives read data, master nack ends
// - every byte acknowledged before the next
// - pointer advances after each transferred word
// - writes past FFh are dropped
// - reads past FFh return FFh
// - read-only targets ignore writes, reserved do not
package tws_pkg;

    localparam logic [6:0] SLAVE_ADDR = 7'h36;
    localparam logic       DIR_WRITE  = 1'h0;
    localparam logic       DIR_READ   = 1'h1;
    localparam logic [2:0] LAST_BIT   = 3'h7;
    localparam logic [2:0] FIRST_BIT  = 3'h0;
    localparam logic [8:0] PTR_END    = 9'h100;
    localparam logic [8:0] PTR_ONE    = 9'h001;
    localparam logic [7:0] FILL_BYTE  = 8'hFF;
    localparam int         ADDR_W     = 8;
    localparam int         WORD_W     = 16;

    // gray codes along idle, address, ack, pointer, data
    typedef enum logic [3:0] {
        TWS_IDLE      = 4'h0,
        TWS_ADDR      = 4'h1,
        TWS_ADDR_ACK  = 4'h3,
        TWS_PTR       = 4'h2,
        TWS_PTR_ACK   = 4'h6,
        TWS_WDATA     = 4'h7,
        TWS_WDATA_ACK = 4'h5,
        TWS_RDATA     = 4'h4,
        TWS_RDATA_ACK = 4'hC
    } tws_state_t;

    // one register word write toward the register space
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } tws_wr_t;

    localparam int WR_W = ADDR_W + WORD_W;

endpackage

// ===== rtl/tws_sync.sv
// two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module tws_sync #(
    parameter logic IDLE_LEVEL = 1'h0
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic d,
    output var  logic q
);
    logic meta_reg;

    // first stage feeds only the second
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_reg <= IDLE_LEVEL; // match the line's rest level
            q        <= IDLE_LEVEL;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/tws_cross.sv
// toggle handshake carrying a request and its answer between two clocks
`timescale 1ns/10ps
`default_nettype none
module tws_cross #(
    parameter int REQ_W = 8,
    parameter int RSP_W = 16
) (
    input  wire logic             srcClk,
    input  wire logic             srcReset,
    input  wire logic             srcStart,
    input  wire logic [REQ_W-1:0] srcReq,
    output var  logic             srcBusy,
    output var  logic             srcDone,
    output var  logic [RSP_W-1:0] srcRsp,
    input  wire logic             dstClk,
    input  wire logic             dstReset,
    output var  logic             dstPulse,
    output var  logic [REQ_W-1:0] dstReq,
    input  wire logic             dstRspValid,
    input  wire logic [RSP_W-1:0] dstRsp
);
    logic             reqTgl_reg;
    logic [REQ_W-1:0] reqHold_reg;
    logic             ackTgl_reg;
    logic [RSP_W-1:0] rspHold_reg;
    logic             ackSync;
    logic             ackSeen_reg;
    logic             reqSync;
    logic             reqSeen_reg;

    tws_sync ackSyncInst (.clk(srcClk), .reset(srcReset), .d(ackTgl_reg), .q(ackSync));
    tws_sync reqSyncInst (.clk(dstClk), .reset(dstReset), .d(reqTgl_reg), .q(reqSync));

    // source side: hold the request until the toggle comes back
    always_ff @(posedge srcClk or posedge srcReset) begin
        if (srcReset) begin
            reqTgl_reg  <= 1'h0;
            reqHold_reg <= '0;
            srcBusy     <= 1'h0;
            ackSeen_reg <= 1'h0;
            srcDone     <= 1'h0;
            srcRsp      <= '0;
        end else begin
            ackSeen_reg <= ackSync;
            srcDone     <= ackSync ^ ackSeen_reg;
            if (ackSync ^ ackSeen_reg) begin
                srcRsp  <= rspHold_reg; // stable since before the toggle
                srcBusy <= 1'h0;
            end
            // a start in the answer's cycle is kept, the later set wins
            if (srcStart && (!srcBusy || (ackSync ^ ackSeen_reg))) begin
                reqTgl_reg  <= ~reqTgl_reg;
                reqHold_reg <= srcReq;
                srcBusy     <= 1'h1;
            end
        end
    end

    // destination side: one pulse per toggle, answer returns as toggle
    always_ff @(posedge dstClk or posedge dstReset) begin
        if (dstReset) begin
            reqSeen_reg <= 1'h0;
            dstPulse    <= 1'h0;
            dstReq      <= '0;
            ackTgl_reg  <= 1'h0;
            rspHold_reg <= '0;
        end else begin
            reqSeen_reg <= reqSync;
            dstPulse    <= reqSync ^ reqSeen_reg;
            if (reqSync ^ reqSeen_reg) begin
                dstReq <= reqHold_reg;
            end
            if (dstRspValid) begin
                rspHold_reg <= dstRsp;
                ackTgl_reg  <= ~ackTgl_reg;
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtl/tws_slave_port.sv
// two-wire slave port giving a bus master access to a 16-bit register space
`timescale 1ns/10ps
`default_nettype none
module tws_slave_port (
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire logic                         linkClk,
    input  wire logic                         sclIn,
    input  wire logic                         sdaIn,
    output var  logic                         sdaOut,
    output var  logic                         sdaOe,
    output var  tws_pkg::tws_wr_t             regWr,
    output var  logic                         regWrEn,
    input  wire logic                         regWrProtect,
    output var  logic                         regRdReq,
    output var  logic [tws_pkg::ADDR_W-1:0]   regRdAddr,
    input  wire logic [tws_pkg::WORD_W-1:0]   regRdData,
    input  wire logic                         regRdValid
);
    import tws_pkg::*;

    // saturating word pointer; FFh steps into the dead zone and stays
    function automatic logic [8:0] ptrInc(input logic [8:0] p);
        logic [8:0] r;
        r = p;
        if (p != PTR_END) begin
            r = p + PTR_ONE;
        end
        return r;
    endfunction

    tws_state_t         state_reg;
    tws_state_t         state_next;
    logic               sclS;
    logic               sdaS;
    logic               sclD_reg;
    logic               sdaD_reg;
    logic               busStart;
    logic               busStop;
    logic               sclRise;
    logic               sclFall;
    logic               inByte;
    logic               lastRise;
    logic [7:0]         byteIn;
    logic               addrHit;
    logic [2:0]         bitCnt_reg;
    logic [7:0]         rxShift_reg;
    logic               byteRdy_reg;
    logic               hit_reg;
    logic               dir_reg;
    logic               mAck_reg;
    logic [8:0]         ptr_reg;
    logic               hiSel_reg;
    logic [7:0]         lowHold_reg;
    logic [7:0]         txShift_reg;
    logic [WORD_W-1:0]  rdWord_reg;
    logic [7:0]         curByte;
    logic               addrDone;
    logic               ptrDone;
    logic               wDone;
    logic               rDone;
    logic               wrStart;
    tws_wr_t            wrReqL;
    logic               rdStart;
    logic [ADDR_W-1:0]  rdAddrL;
    logic               rdDoneL;
    logic [WORD_W-1:0]  rdRspL;
    logic               wrPulseC;
    logic [WR_W-1:0]    wrReqC;
    logic               rdPulseC;
    logic [ADDR_W-1:0]  rdReqC;
    logic               wrPend_reg;
    logic [7:0]         nextPtrLow;
    logic [8:0]         nextPtr;

    // pins come from the bus, so both pass two flops first; they reset
    // to the idle high level so no false edge follows reset
    tws_sync #(.IDLE_LEVEL(1'h1)) sclSyncInst (.clk(linkClk), .reset(reset), .d(sclIn), .q(sclS));
    tws_sync #(.IDLE_LEVEL(1'h1)) sdaSyncInst (.clk(linkClk), .reset(reset), .d(sdaIn), .q(sdaS));

    // previous synchronised levels for edge and condition detection
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            sclD_reg <= 1'h1;
            sdaD_reg <= 1'h1;
        end else begin
            sclD_reg <= sclS;
            sdaD_reg <= sdaS;
        end
    end

    // conditions are SDA edges with SCL steady high
    assign busStart = sclS && sclD_reg && sdaD_reg && !sdaS;
    assign busStop  = sclS && sclD_reg && !sdaD_reg && sdaS;
    assign sclRise  = sclS && !sclD_reg;
    assign sclFall  = !sclS && sclD_reg;

    // byte decode; oversampling makes any SCL rate to 400kHz work unconfigured
    assign inByte   = (state_reg == TWS_ADDR) || (state_reg == TWS_PTR) ||
                      (state_reg == TWS_WDATA) || (state_reg == TWS_RDATA);
    assign lastRise = sclRise && inByte && (bitCnt_reg == LAST_BIT);
    assign byteIn   = {rxShift_reg[6:0], sdaS};
    assign addrHit  = (byteIn[7:1] == SLAVE_ADDR);
    assign addrDone = lastRise && (state_reg == TWS_ADDR);
    assign ptrDone  = lastRise && (state_reg == TWS_PTR);
    assign wDone    = lastRise && (state_reg == TWS_WDATA);
    assign rDone    = lastRise && (state_reg == TWS_RDATA);

    // next pointer, shared by read prefetch and the advance
    assign nextPtr    = ptrInc(ptr_reg);
    assign nextPtrLow = nextPtr[7:0];

    // byte to shift out: low half first, fill past the end
    always_comb begin
        curByte = hiSel_reg ? rdWord_reg[15:8] : rdWord_reg[7:0];
        if (ptr_reg[8]) begin
            curByte = FILL_BYTE;
        end
    end

    // protocol sequence; conditions override any phase
    always_comb begin
        state_next = state_reg;
        if (busStart) begin
            state_next = TWS_ADDR;
        end else if (busStop) begin
            state_next = TWS_IDLE;
        end else if (sclFall) begin
            unique case (state_reg)
                TWS_IDLE: begin
                    state_next = TWS_IDLE;
                end
                TWS_ADDR: begin
                    if (byteRdy_reg) begin
                        state_next = hit_reg ? TWS_ADDR_ACK : TWS_IDLE;
                    end
                end
                TWS_ADDR_ACK: begin
                    state_next = (dir_reg == DIR_READ) ? TWS_RDATA : TWS_PTR;
                end
                TWS_PTR: begin
                    if (byteRdy_reg) begin
                        state_next = TWS_PTR_ACK;
                    end
                end
                TWS_PTR_ACK: begin
                    state_next = TWS_WDATA;
                end
                TWS_WDATA: begin
                    if (byteRdy_reg) begin
                        state_next = TWS_WDATA_ACK;
                    end
                end
                TWS_WDATA_ACK: begin
                    state_next = TWS_WDATA;
                end
                TWS_RDATA: begin
                    if (byteRdy_reg) begin
                        state_next = TWS_RDATA_ACK;
                    end
                end
                TWS_RDATA_ACK: begin
                    state_next = mAck_reg ? TWS_RDATA : TWS_IDLE;
                end
                default: begin
                    state_next = TWS_IDLE;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            state_reg <= TWS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // bit counter restarts outside byte phases
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            bitCnt_reg <= FIRST_BIT;
        end else if (busStart || busStop || !inByte) begin
            bitCnt_reg <= FIRST_BIT;
        end else if (sclRise) begin
            bitCnt_reg <= bitCnt_reg + 3'h1;
        end
    end

    // sample SDA on each rising SCL of a byte phase, MSB arrives first
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            rxShift_reg <= 8'h00;
        end else if (sclRise && inByte) begin
            rxShift_reg <= byteIn;
        end
    end

    // byte complete marker, consumed at the following SCL fall
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            byteRdy_reg <= 1'h0;
        end else if (busStart || busStop) begin
            byteRdy_reg <= 1'h0;
        end else if (lastRise) begin
            byteRdy_reg <= 1'h1;
        end else if (sclFall) begin
            byteRdy_reg <= 1'h0;
        end
    end

    // address match and direction, master ack of read bytes
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            hit_reg  <= 1'h0;
            dir_reg  <= DIR_WRITE;
            mAck_reg <= 1'h0;
        end else begin
            if (addrDone) begin
                hit_reg <= addrHit;
                dir_reg <= byteIn[0];
            end
            if (sclRise && (state_reg == TWS_RDATA_ACK)) begin
                mAck_reg <= !sdaS;
            end
        end
    end

    // pointer and byte half: advance after the high byte's last bit
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            ptr_reg     <= 9'h000;
            hiSel_reg   <= 1'h0;
            lowHold_reg <= 8'h00;
        end else if (busStart) begin
            hiSel_reg <= 1'h0;
        end else if (ptrDone) begin
            ptr_reg   <= {1'h0, byteIn};
            hiSel_reg <= 1'h0;
        end else if (wDone || rDone) begin
            if (!hiSel_reg) begin
                lowHold_reg <= byteIn;
                hiSel_reg   <= 1'h1;
            end else begin
                hiSel_reg <= 1'h0;
                ptr_reg   <= nextPtr;
            end
        end
    end

    // word write once its high byte is in; dead zone drops it
    assign wrStart     = wDone && hiSel_reg && !ptr_reg[8];
    assign wrReqL.addr = ptr_reg[7:0];
    assign wrReqL.data = {byteIn, lowHold_reg};

    // prefetch on read address and after each high byte short of the end, which leaves
    // more than an SCL period for the crossing before the first bit
    assign rdStart = (addrDone && addrHit && (byteIn[0] == DIR_READ) && !ptr_reg[8]) ||
                     (rDone && hiSel_reg && !nextPtr[8]);
    assign rdAddrL = addrDone ? ptr_reg[7:0] : nextPtrLow;

    // returned read word for the shifter
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            rdWord_reg <= {WORD_W{1'h1}};
        end else if (rdDoneL) begin
            rdWord_reg <= rdRspL;
        end
    end

    // transmit shifter loads at the fall that opens a read byte
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            txShift_reg <= 8'h00;
        end else if (sclFall) begin
            if ((state_reg == TWS_ADDR_ACK) || (state_reg == TWS_RDATA_ACK)) begin
                txShift_reg <= curByte;
            end else if (state_reg == TWS_RDATA) begin
                txShift_reg <= {txShift_reg[6:0], 1'h0};
            end
        end
    end

    // open-drain pull-down; changes after SCL falls, or releases at START or STOP,
    // so the line is steady while SCL is high inside a transfer
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            sdaOe <= 1'h0;
        end else if (busStart || busStop) begin
            sdaOe <= 1'h0;
        end else if (sclFall) begin
            unique case (state_reg)
                TWS_IDLE: begin
                    sdaOe <= 1'h0;
                end
                TWS_ADDR: begin
                    sdaOe <= byteRdy_reg && hit_reg;
                end
                TWS_PTR, TWS_WDATA: begin
                    sdaOe <= byteRdy_reg;
                end
                TWS_ADDR_ACK: begin
                    sdaOe <= (dir_reg == DIR_READ) && !curByte[7];
                end
                TWS_PTR_ACK, TWS_WDATA_ACK: begin
                    sdaOe <= 1'h0;
                end
                TWS_RDATA: begin
                    sdaOe <= !byteRdy_reg && !txShift_reg[6];
                end
                TWS_RDATA_ACK: begin
                    sdaOe <= mAck_reg && !curByte[7];
                end
                default: begin
                    sdaOe <= 1'h0;
                end
            endcase
        end
    end

    // never drives high and has no SCL output at all
    assign sdaOut = 1'h0;

    // write word crossing; one word in flight, master bit rate keeps it so
    tws_cross #(
        .REQ_W (WR_W),
        .RSP_W (1)
    ) wrCrossInst (
        .srcClk      (linkClk),
        .srcReset    (reset),
        .srcStart    (wrStart),
        .srcReq      (wrReqL),
        .srcBusy     (),
        .srcDone     (),
        .srcRsp      (),
        .dstClk      (clk),
        .dstReset    (reset),
        .dstPulse    (wrPulseC),
        .dstReq      (wrReqC),
        .dstRspValid (wrPend_reg),
        .dstRsp      (1'h0)
    );

    // read word crossing, answered by the register space
    tws_cross #(
        .REQ_W (ADDR_W),
        .RSP_W (WORD_W)
    ) rdCrossInst (
        .srcClk      (linkClk),
        .srcReset    (reset),
        .srcStart    (rdStart),
        .srcReq      (rdAddrL),
        .srcBusy     (),
        .srcDone     (rdDoneL),
        .srcRsp      (rdRspL),
        .dstClk      (clk),
        .dstReset    (reset),
        .dstPulse    (rdPulseC),
        .dstReq      (rdReqC),
        .dstRspValid (regRdValid),
        .dstRsp      (regRdData)
    );

    // register-space write strobe, one clk cycle per word
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wrPend_reg <= 1'h0;
            regWr      <= '0;
        end else begin
            wrPend_reg <= wrPulseC;
            if (wrPulseC) begin
                regWr <= tws_wr_t'(wrReqC);
            end
        end
    end

    // protected targets swallow the word; reserved ones are not flagged
    assign regWrEn = wrPend_reg && !regWrProtect;

    // register-space read request pulse
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            regRdReq  <= 1'h0;
            regRdAddr <= '0;
        end else begin
            regRdReq <= rdPulseC;
            if (rdPulseC) begin
                regRdAddr <= rdReqC;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/tws_slave_port_assertions.sv
// pin and register-interface checks for the two-wire slave port
`timescale 1ns/10ps
`default_nettype none
module tws_slave_port_assertions (
    input wire logic                       clk,
    input wire logic                       reset,
    input wire logic                       linkClk,
    input wire logic                       sclIn,
    input wire logic                       sdaOut,
    input wire logic                       sdaOe,
    input wire logic                       regWrEn,
    input wire logic                       regWrProtect,
    input wire logic                       regRdReq,
    input wire logic [tws_pkg::ADDR_W-1:0] regRdAddr
);
    import tws_pkg::*;
    // open drain: the pin level itself is never driven high
    open_drain_a: assert property (
        @(posedge linkClk) disable iff (reset) !sdaOut)
        else $error("sda output level not low");
    // six high samples of scl: the bus has settled, no drive change
    bit_stable_a: assert property (
        @(posedge linkClk) disable iff (reset) sclIn [*6] |-> $stable(sdaOe))
        else $error("sda drive moved while scl high");
    drive_start_a: assert property (
        @(posedge linkClk) disable iff (reset) $rose(sdaOe) |-> !sclIn)
        else $error("sda pulled low while scl high");
    // limitation: an abort while the device drives would also trip this
    drive_end_a: assert property (
        @(posedge linkClk) disable iff (reset) $fell(sdaOe) |-> !sclIn)
        else $error("sda released while scl high");
    protect_drop_a: assert property (
        @(posedge clk) disable iff (reset) regWrProtect |-> !regWrEn)
        else $error("write reached a read-only target");
    write_pulse_a: assert property (
        @(posedge clk) disable iff (reset) regWrEn |=> !regWrEn)
        else $error("write strobe longer than one cycle");
    read_pulse_a: assert property (
        @(posedge clk) disable iff (reset) regRdReq |=> !regRdReq)
        else $error("read request longer than one cycle");
    read_addr_a: assert property (
        @(posedge clk) disable iff (reset) $changed(regRdAddr) |-> regRdReq)
        else $error("read address moved without a request");
endmodule
`default_nettype wire

// ===== tb/tws_bus_master.sv
// behavioural two-wire bus master facing the slave port
`timescale 1ns/10ps
`default_nettype none
module tws_bus_master (
    output var  logic scl,
    output var  logic sdaLow,
    input  wire logic sda
);
    // quarter bit at 400kHz; sda moves a quarter after scl falls
    localparam time Q = 625ns;
    initial begin
        scl = 1'h1;
        sdaLow = 1'h0;
    end
    // start, also used as repeated start
    task automatic start();
        #Q sdaLow = 1'h0;
        #Q scl = 1'h1;
        #Q sdaLow = 1'h1;
        #Q scl = 1'h0;
    endtask
    task automatic stop();
        #Q sdaLow = 1'h1;
        #Q scl = 1'h1;
        #Q sdaLow = 1'h0;
        #Q;
    endtask
    // data set while scl low, sampled at the end of scl high
    task automatic bitx(input logic b, output logic r);
        #Q sdaLow = !b;
        #Q scl = 1'h1;
        #(2*Q) r = sda;
        scl = 1'h0;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(b[i], r);
        bitx(1'h1, ack);
    endtask
    // nack on the last wanted byte hands sda back
    task automatic rbyte(output logic [7:0] b, input logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'h1, b[i]);
        bitx(nack, r);
    endtask
endmodule
`default_nettype wire

// ===== tb/test_tws_slave_port.sv
// self-checking bench for the two-wire slave port
`timescale 1ns/10ps
`default_nettype none
module test_tws_slave_port;
    import tws_pkg::*;
    logic              clk;
    logic              reset;
    logic              linkClk;
    logic              scl;
    logic              sdaLow;
    logic              sda;
    logic              sdaOut;
    logic              sdaOe;
    tws_wr_t           regWr;
    logic              regWrEn;
    logic              regWrProtect;
    logic              regRdReq;
    logic [ADDR_W-1:0] regRdAddr;
    logic [WORD_W-1:0] regRdData = 16'h0000;
    logic              regRdValid = 1'h0;
    logic [15:0]       mem [256];
    logic [15:0]       wData [3];
    logic [15:0]       oldFe;
    logic [23:0]       wrQ [$];
    logic [7:0]        rdQ [$];
    logic [7:0]        raQ [$];
    logic [7:0]        rb;
    logic [7:0]        rdAddr = 8'h00;
    logic              ack;
    int                seed;
    int                rdWait = 0;
    int                cycles = 0;
    int                failures = 0;
    int                tests_run = 0;

    // wired-and bus with pull-up
    assign sda = ~(sdaOe | sdaLow);
    // FEh stands for a read-only register here
    assign regWrProtect = (regWr.addr == 8'hFE);

    tws_slave_port DUT (
        .clk(clk), .reset(reset), .linkClk(linkClk), .sclIn(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .regWr(regWr), .regWrEn(regWrEn),
        .regWrProtect(regWrProtect), .regRdReq(regRdReq), .regRdAddr(regRdAddr),
        .regRdData(regRdData), .regRdValid(regRdValid)
    );
    tws_bus_master m (.scl(scl), .sdaLow(sdaLow), .sda(sda));

    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    // link clock, phase unrelated to clk
    initial begin
        linkClk = 1'h0;
        #7;
        forever #15 linkClk = ~linkClk;
    end

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: seen %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic tx(input logic [7:0] b, input logic a);
        m.wbyte(b, ack);
        check(24'(ack), 24'(a));
    endtask

    // register space, write monitor and run limit; answers lag 1..4 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            report_and_stop();
        end
        if (regRdReq === 1'h1) begin
            rdAddr = regRdAddr;
            check(24'(regRdAddr), raQ.size() > 0 ? 24'(raQ.pop_front()) : 24'(~regRdAddr));
            rdWait = 1 + ($random(seed) & 3);
        end
        if (regWrEn === 1'h1) begin
            mem[regWr.addr] = regWr.data;
            check(regWr, wrQ.size() > 0 ? wrQ.pop_front() : ~regWr);
        end
        #1;
        regRdValid = (rdWait == 1);
        regRdData = mem[rdAddr];
        if (rdWait != 0)
            rdWait--;
    end

    initial begin
        seed = 35;
        reset = 1'h1;
        foreach (mem[i]) mem[i] = $random(seed);
        foreach (wData[i]) wData[i] = $random(seed);
        oldFe = mem[8'hFE];
        repeat (10) @(posedge clk);
        #1 reset = 1'h0;
        repeat (20) @(posedge clk);
        // foreign address ignored, the retry with the own address acked
        m.start();
        tx(8'h6E, 1'h1);
        m.stop();
        m.start();
        tx(8'h6C, 1'h0);
        m.stop();
        // words to FEh (read-only), FFh, then past the end
        wrQ.push_back({8'hFF, wData[1]});
        m.start();
        tx(8'h6C, 1'h0);
        tx(8'hFE, 1'h0);
        foreach (wData[i]) begin
            tx(wData[i][7:0], 1'h0);
            tx(wData[i][15:8], 1'h0);
        end
        m.stop();
        // pointer, repeated start, read across the end
        rdQ = {oldFe[7:0], oldFe[15:8], wData[1][7:0], wData[1][15:8], 8'hFF, 8'hFF};
        raQ = {8'hFE, 8'hFF};
        m.start();
        tx(8'h6C, 1'h0);
        tx(8'hFE, 1'h0);
        m.start();
        tx(8'h6D, 1'h0);
        for (int i = 0; i < 6; i++) begin
            m.rbyte(rb, i == 5);
            check(24'(rb), 24'(rdQ.pop_front()));
        end
        m.stop();
        repeat (20) @(posedge clk);
        check(24'(wrQ.size() + raQ.size()), 24'h000000);
        report_and_stop();
    end
endmodule

bind tws_slave_port tws_slave_port_assertions u_chk (
    .clk(clk), .reset(reset), .linkClk(linkClk), .sclIn(sclIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .regWrEn(regWrEn), .regWrProtect(regWrProtect),
    .regRdReq(regRdReq), .regRdAddr(regRdAddr)
);
`default_nettype wire
